// File: design/wct_cfg.svh
// Constants of the wide capture timer: register indices, field positions,
// reset values and bus answers. Assumes an AXI4-Lite slave with byte
// address = 4 * register index and 32-bit data.
`ifndef WCT_CFG_SVH
`define WCT_CFG_SVH

// Register indices; byte address is four times the index
`define WCT_IDX_CTRL0   32'h008003EB
`define WCT_IDX_CTRL1   32'h008003EC
`define WCT_IDX_CNT0    32'h008003F0
`define WCT_IDX_CNT1    32'h008003F1
`define WCT_IDX_STAT    32'h008003F2
`define WCT_IDX_IEN     32'h008003F3
`define WCT_IDX_ICLR    32'h008003F4
`define WCT_IDX_CAP0    32'h008003F8

// Control register fields (bit 15 of the big-endian view is data bit 0)
`define WCT_CKS_BIT     0
`define WCT_SS_CH0_BIT  7
`define WCT_CTRL_MASK   8'hF1
`define WCT_CTRL_RST    8'h00

// Counter reset and maximum values, status and enable reset values
`define WCT_CNT_RST     32'h00000000
`define WCT_CNT_MAX     32'hFFFFFFFF
`define WCT_STAT_RST    4'h0
`define WCT_IEN_RST     4'h0

// Bus answers
`define WCT_RESP_OKAY   2'h0
`define WCT_RESP_SLVERR 2'h2

`endif

// File: design/wct_pkg.sv
// Types of the wide capture timer: bus channel bundles, event inputs,
// register selector and read sequencer states.
// Assumes AXI4-Lite with 32-bit address and data.
package wct_pkg;

    // Master to slave signals of the register bus
    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } wct_axil_req_t;

    // Slave to master signals of the register bus
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } wct_axil_rsp_t;

    // Measure event sources and the shared clock bus line
    typedef struct packed {
        logic [3:0] ext_measure_pin;
        logic [3:0] evt_bus;
        logic       clk_bus1;
    } wct_evt_in_t;

    typedef enum logic [3:0] {
        SEL_NONE, SEL_CTRL0, SEL_CTRL1, SEL_CNT0, SEL_CNT1,
        SEL_STAT, SEL_IEN, SEL_ICLR, SEL_CAP
    } wct_reg_sel_t;

    typedef enum {RD_IDLE, RD_WAIT, RD_RESP} wct_rd_state_t;

endpackage

// File: design/wct_capture_mem.sv
// Eight 32-bit capture registers with one registered read port.
// Assumes one write strobe per channel; channels 0-3 take block zero's
// value, channels 4-7 take block one's.
`timescale 1ns/100ps
`include "wct_cfg.svh"

module wct_capture_mem (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  we_i,
    input  wire logic [31:0] blk0_val_i,
    input  wire logic [31:0] blk1_val_i,
    input  wire logic [2:0]  raddr_i,
    output logic      [31:0] rdata_o
);
    logic [31:0] cap [0:7];

    // Each channel loads only on its own strobe
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < 8; i++)
                cap[i] <= `WCT_CNT_RST;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
                if (we_i[i])
                    cap[i] <= (i < 4) ? blk0_val_i : blk1_val_i;
        end
    end

    // Registered read port
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= `WCT_CNT_RST;
        else
            rdata_o <= cap[raddr_i];
    end

    // A strobed channel holds the block value of the strobe cycle
    property p_cap_load;
        @(posedge clk_i) disable iff (!rst_n_i)
        we_i[0] |=> cap[0] == $past(blk0_val_i);
    endproperty
    a_cap_load: assert property (p_cap_load) else $error("capture 0 missed value");

    // An unstrobed channel keeps its value
    property p_cap_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        !we_i[4] |=> $stable(cap[4]);
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capture 4 changed");

endmodule

// File: design/wct_timer.sv
// Wide capture timer: two free-running 32-bit counters, eight capture
// channels, block zero measure interrupt, AXI4-Lite register slave.
// Assumes all inputs synchronous to MCLK_I; one write and one read at a time.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "wct_cfg.svh"

module wct_timer (
    input  wire logic                   MCLK_I,
    input  wire logic                   RST_N_I,
    input  wire wct_pkg::wct_axil_req_t AXIL_REQ_I,
    output wct_pkg::wct_axil_rsp_t      AXIL_RSP_O,
    input  wire wct_pkg::wct_evt_in_t   EVT_I,
    output logic                        IRQ_O
);
    import wct_pkg::*;

    // Address to register selector
    function automatic wct_reg_sel_t decode(input logic [31:0] addr);
        logic [29:0] idx;
        idx = addr[31:2];
        if (idx == `WCT_IDX_CTRL0)
            decode = SEL_CTRL0;
        else if (idx == `WCT_IDX_CTRL1)
            decode = SEL_CTRL1;
        else if (idx == `WCT_IDX_CNT0)
            decode = SEL_CNT0;
        else if (idx == `WCT_IDX_CNT1)
            decode = SEL_CNT1;
        else if (idx == `WCT_IDX_STAT)
            decode = SEL_STAT;
        else if (idx == `WCT_IDX_IEN)
            decode = SEL_IEN;
        else if (idx == `WCT_IDX_ICLR)
            decode = SEL_ICLR;
        else if (idx[29:3] == `WCT_IDX_CAP0 >> 3)
            decode = SEL_CAP;
        else
            decode = SEL_NONE;
    endfunction

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        merge = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                merge[i*8 +: 8] = data[i*8 +: 8];
    endfunction

    logic [7:0]    ctrl0;
    logic [7:0]    ctrl1;
    logic [31:0]   cnt [0:1];
    logic [31:0]   next_cnt [0:1];
    logic [31:0]   cap_val [0:1];
    logic [1:0]    cnt_wr;
    logic [1:0]    tick;
    logic          div_phase;
    logic          cb_prev;
    logic [3:0]    ext_prev;
    logic [3:0]    bus_prev;
    logic [3:0]    ext_rise;
    logic [3:0]    bus_rise;
    logic [3:0]    evt0;
    logic [3:0]    evt1;
    logic [3:0]    stat;
    logic [3:0]    ien;
    logic [3:0]    clr;
    logic          aw_hold;
    logic          w_hold;
    logic [31:0]   aw_addr_q;
    logic [31:0]   w_data_q;
    logic [3:0]    w_strb_q;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          have_aw;
    logic          have_w;
    logic          wr_go;
    logic [31:0]   wr_addr;
    logic [31:0]   wr_data;
    logic [3:0]    wr_strb;
    wct_reg_sel_t  wr_sel;
    wct_rd_state_t rd_state;
    wct_reg_sel_t  rd_sel;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic [2:0]    cap_raddr;
    logic [31:0]   cap_rdata;

    // Half-rate count enable and clock bus edge; no stop control exists
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            div_phase <= 1'b0;
            cb_prev   <= 1'b0;
        end
        else
        begin
            div_phase <= ~div_phase;
            cb_prev   <= EVT_I.clk_bus1;
        end
    end

    // Count clock selection per block
    assign tick[0] = ctrl0[`WCT_CKS_BIT] ? (EVT_I.clk_bus1 & ~cb_prev)
                                         : div_phase;
    assign tick[1] = ctrl1[`WCT_CKS_BIT] ? (EVT_I.clk_bus1 & ~cb_prev)
                                         : div_phase;

    // Edge detection of every event source
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ext_prev <= 4'h0;
            bus_prev <= 4'h0;
        end
        else
        begin
            ext_prev <= EVT_I.ext_measure_pin;
            bus_prev <= EVT_I.evt_bus;
        end
    end

    assign ext_rise = EVT_I.ext_measure_pin & ~ext_prev;
    assign bus_rise = EVT_I.evt_bus & ~bus_prev;

    // Channel source selection; block one has no pin, only the event bus
    always_comb
    begin
        for (int c = 0; c < 4; c++)
        begin
            evt0[c] = ctrl0[`WCT_SS_CH0_BIT - c] ? bus_rise[c] : ext_rise[c];
            evt1[c] = ctrl1[`WCT_SS_CH0_BIT - c] & bus_rise[c];
        end
    end

    // Bus write path: address and data taken in either order
    assign have_aw = aw_hold | AXIL_REQ_I.awvalid;
    assign have_w  = w_hold | AXIL_REQ_I.wvalid;
    assign wr_go   = have_aw & have_w & ~bvalid;
    assign wr_addr = aw_hold ? aw_addr_q : AXIL_REQ_I.awaddr;
    assign wr_data = w_hold ? w_data_q : AXIL_REQ_I.wdata;
    assign wr_strb = w_hold ? w_strb_q : AXIL_REQ_I.wstrb;
    assign wr_sel  = decode(wr_addr);

    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            aw_hold   <= 1'b0;
            w_hold    <= 1'b0;
            aw_addr_q <= 32'h00000000;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `WCT_RESP_OKAY;
        end
        else
        begin
            if (wr_go)
            begin
                aw_hold <= 1'b0;
                w_hold  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= (wr_sel == SEL_NONE) ? `WCT_RESP_SLVERR : `WCT_RESP_OKAY;
            end
            else
            begin
                if (AXIL_REQ_I.awvalid && !aw_hold && !bvalid)
                begin
                    aw_hold   <= 1'b1;
                    aw_addr_q <= AXIL_REQ_I.awaddr;
                end
                if (AXIL_REQ_I.wvalid && !w_hold && !bvalid)
                begin
                    w_hold   <= 1'b1;
                    w_data_q <= AXIL_REQ_I.wdata;
                    w_strb_q <= AXIL_REQ_I.wstrb;
                end
                if (bvalid && AXIL_REQ_I.bready)
                    bvalid <= 1'b0;
            end
        end
    end

    // Control and interrupt enable registers
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ctrl0 <= `WCT_CTRL_RST;
            ctrl1 <= `WCT_CTRL_RST;
            ien   <= `WCT_IEN_RST;
        end
        else if (wr_go && wr_strb[0])
        begin
            if (wr_sel == SEL_CTRL0)
                ctrl0 <= wr_data[7:0] & `WCT_CTRL_MASK;
            if (wr_sel == SEL_CTRL1)
                ctrl1 <= wr_data[7:0] & `WCT_CTRL_MASK;
            if (wr_sel == SEL_IEN)
                ien <= wr_data[3:0];
        end
    end

    // Counter next values: write wins, else count up and wrap silently
    assign cnt_wr[0] = wr_go && (wr_sel == SEL_CNT0);
    assign cnt_wr[1] = wr_go && (wr_sel == SEL_CNT1);

    always_comb
    begin
        for (int b = 0; b < 2; b++)
        begin
            cap_val[b] = cnt_wr[b] ? merge(cnt[b], wr_data, wr_strb) : cnt[b];
            if (cnt_wr[b])
                next_cnt[b] = cap_val[b];
            else if (tick[b])
                next_cnt[b] = cnt[b] + 32'h00000001;
            else
                next_cnt[b] = cnt[b];
        end
    end

    // Two independent counters
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            cnt[0] <= `WCT_CNT_RST;
            cnt[1] <= `WCT_CNT_RST;
        end
        else
        begin
            cnt[0] <= next_cnt[0];
            cnt[1] <= next_cnt[1];
        end
    end

    // Capture storage; a same-cycle counter write is what gets captured
    wct_capture_mem u_cap (
        .clk_i      (MCLK_I),
        .rst_n_i    (RST_N_I),
        .we_i       ({evt1, evt0}),
        .blk0_val_i (cap_val[0]),
        .blk1_val_i (cap_val[1]),
        .raddr_i    (cap_raddr),
        .rdata_o    (cap_rdata)
    );

    assign cap_raddr = AXIL_REQ_I.araddr[4:2];

    // Sticky status from block zero events only; set wins over clear
    assign clr = (wr_go && wr_sel == SEL_ICLR && wr_strb[0]) ? wr_data[3:0] : 4'h0;

    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            stat  <= `WCT_STAT_RST;
            IRQ_O <= 1'b0;
        end
        else
        begin
            stat  <= (stat & ~clr) | evt0;
            IRQ_O <= |(stat & ien);
        end
    end

    // Read sequencer: address taken, one wait cycle for capture data
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rd_state <= RD_IDLE;
            rd_sel   <= SEL_NONE;
            rdata    <= 32'h00000000;
            rresp    <= `WCT_RESP_OKAY;
        end
        else
        begin
            case (rd_state)
                RD_IDLE:
                begin
                    if (AXIL_REQ_I.arvalid)
                    begin
                        rd_sel   <= decode(AXIL_REQ_I.araddr);
                        rd_state <= RD_WAIT;
                    end
                end
                RD_WAIT:
                begin
                    rresp    <= (rd_sel == SEL_NONE) ? `WCT_RESP_SLVERR : `WCT_RESP_OKAY;
                    rd_state <= RD_RESP;
                    case (rd_sel)
                        SEL_CTRL0: rdata <= {24'h000000, ctrl0};
                        SEL_CTRL1: rdata <= {24'h000000, ctrl1};
                        SEL_CNT0:  rdata <= cnt[0];
                        SEL_CNT1:  rdata <= cnt[1];
                        SEL_STAT:  rdata <= {28'h0000000, stat};
                        SEL_IEN:   rdata <= {28'h0000000, ien};
                        SEL_CAP:   rdata <= cap_rdata;
                        default:   rdata <= 32'h00000000;
                    endcase
                end
                RD_RESP:
                begin
                    if (AXIL_REQ_I.rready)
                        rd_state <= RD_IDLE;
                end
                default:
                    rd_state <= RD_IDLE;
            endcase
        end
    end

    // Bus answer bundle
    always_comb
    begin
        AXIL_RSP_O.awready = ~aw_hold & ~bvalid;
        AXIL_RSP_O.wready  = ~w_hold & ~bvalid;
        AXIL_RSP_O.bvalid  = bvalid;
        AXIL_RSP_O.bresp   = bresp;
        AXIL_RSP_O.arready = (rd_state == RD_IDLE);
        AXIL_RSP_O.rvalid  = (rd_state == RD_RESP);
        AXIL_RSP_O.rdata   = rdata;
        AXIL_RSP_O.rresp   = rresp;
    end

    // Counting step of one per count clock tick
    property p_cnt_step;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        tick[0] && !cnt_wr[0] && cnt[0] != `WCT_CNT_MAX |=> cnt[0] == $past(cnt[0]) + 32'h1;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter 0 bad step");

    // Counter never stops: half clock gives at least one step in three cycles
    property p_free_run;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (!ctrl1[`WCT_CKS_BIT] && !cnt_wr[1] && cnt[1] < 32'h0000FFFF) [*4]
        |-> cnt[1] - $past(cnt[1], 3) >= 32'h1;
    endproperty
    a_free_run: assert property (p_free_run) else $error("counter 1 stalled");

    // Half clock ticks alternate
    property p_half_clk;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        !ctrl0[`WCT_CKS_BIT] && tick[0] |=> !tick[0] ##1 (tick[0] || ctrl0[`WCT_CKS_BIT]);
    endproperty
    a_half_clk: assert property (p_half_clk) else $error("half clock tick wrong");

    // Clock bus rising edge counts when selected
    property p_bus_clk;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        ctrl0[`WCT_CKS_BIT] && $rose(EVT_I.clk_bus1) |-> tick[0];
    endproperty
    a_bus_clk: assert property (p_bus_clk) else $error("clock bus edge missed");

    // Pin source selected: a pin edge is channel 0's event
    property p_src_pin;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        !ctrl0[`WCT_SS_CH0_BIT] && ext_rise[0] |-> evt0[0];
    endproperty
    a_src_pin: assert property (p_src_pin) else $error("pin event lost");

    // Block zero event sets status next cycle, interrupt one cycle later
    property p_irq;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        evt0[0] && ien[0] && $stable(ien) |=> stat[0] ##1 IRQ_O;
    endproperty
    a_irq: assert property (p_irq) else $error("measure interrupt missing");

    // Status rises only from a block zero event, never from overflow
    property p_stat_cause;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        $rose(stat[1]) |-> $past(evt0[1]);
    endproperty
    a_stat_cause: assert property (p_stat_cause) else $error("status without event");

    // Wrap to zero at maximum
    property p_wrap;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        tick[0] && !cnt_wr[0] && cnt[0] == `WCT_CNT_MAX |=> cnt[0] == `WCT_CNT_RST;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter 0 did not wrap");

    c_capture: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) evt0[0] && tick[0]);
    c_irq: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) $rose(IRQ_O));
    c_cnt_wr: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) cnt_wr[0] && evt0[3]);

endmodule

// File: tb/wct_evt_src.sv
// Model of the pulse sources, event bus lines and clock bus line 1.
// Assumes callers enter its tasks just after a rising edge of clk_i.
`timescale 1ns/100ps

module wct_evt_src (
    input  wire logic            clk_i,
    output wct_pkg::wct_evt_in_t evt_o
);
    import wct_pkg::*;

    // All lines rest low, clock bus line stands still
    initial evt_o = '0;

    // One pulse two cycles wide on a pin or an event bus line
    task automatic pulse(input logic on_bus, input int c);
        if (on_bus)
            evt_o.evt_bus[c] <= 1'b1;
        else
            evt_o.ext_measure_pin[c] <= 1'b1;
        repeat (2) @(posedge clk_i);
        evt_o.evt_bus[c] <= 1'b0;
        evt_o.ext_measure_pin[c] <= 1'b0;
    endtask

    // A burst of n periods on clock bus line 1, still afterwards
    task automatic clk_pulses(input int n);
        repeat (n)
        begin
            evt_o.clk_bus1 <= 1'b1;
            repeat (2) @(posedge clk_i);
            evt_o.clk_bus1 <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask
endmodule

// File: tb/wct_timer_tb.sv
// Self-checking bench of the wide capture timer over AXI4-Lite.
// Assumes the design files and the event source model are compiled first.
`timescale 1ns/100ps
`include "wct_cfg.svh"

module wct_timer_tb;
    import wct_pkg::*;

    logic          mclk;
    logic          rst_n;
    wct_axil_req_t req;
    wct_axil_rsp_t rsp;
    wct_evt_in_t   evt;
    logic          irq;
    int            err_total = 0;
    int            num_checks = 0;
    int            cyc = 0;
    int            t_ar;
    int            ta;
    logic [31:0]   a;
    logic [31:0]   b;
    logic [31:0]   p;
    logic [31:0]   v;
    logic [1:0]    r;

    wct_timer i_dut (.MCLK_I(mclk), .RST_N_I(rst_n), .AXIL_REQ_I(req), .AXIL_RSP_O(rsp),
                     .EVT_I(evt), .IRQ_O(irq));
    wct_evt_src i_src (.clk_i(mclk), .evt_o(evt));

    // 125 MHz clock and cycle count
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Write one word; address and data offered together
    task automatic wr(input logic [31:0] idx, input logic [31:0] d);
        req.awaddr <= idx << 2;
        req.wdata <= d;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        r = rsp.bresp;
    endtask

    // Read one word; t_ar keeps the cycle the address was taken
    task automatic rd(input logic [31:0] idx);
        req.araddr <= idx << 2;
        req.arvalid <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (req.arvalid && rsp.arready === 1'b1)
            begin
                req.arvalid <= 1'b0;
                t_ar = cyc;
            end
        end while (rsp.rvalid !== 1'b1);
        v = rsp.rdata;
        r = rsp.rresp;
    endtask

    // Counts and verdict
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        #400000;
        err_total++;
        finish_test;
    end

    // Main sequence; response channels always ready
    initial
    begin
        rst_n = 1'b0;
        req = '0;
        req.wstrb = 4'hF;
        req.bready = 1'b1;
        req.rready = 1'b1;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        // Reset values
        rd(`WCT_IDX_CTRL0);
        chk(v, 32'h0);
        rd(`WCT_IDX_STAT);
        chk(v, 32'h0);
        chk(irq, 1'b0);
        // Counter runs at half clock from release
        rd(`WCT_IDX_CNT0);
        a = v;
        ta = t_ar;
        repeat (50) @(posedge mclk);
        rd(`WCT_IDX_CNT0);
        chk(2 * (v - a) + 1 >= t_ar - ta && 2 * (v - a) <= t_ar - ta + 1, 1);
        // Writable control bits
        wr(`WCT_IDX_CTRL0, 32'hFFFFFFFF);
        rd(`WCT_IDX_CTRL0);
        chk(v, 32'hF1);
        // Source select per channel, pin then event bus line
        for (int c = 0; c < 4; c++)
            for (int s = 0; s < 2; s++)
            begin
                wr(`WCT_IDX_CTRL0, s ? 32'h80 >> c : 32'h0);
                rd(`WCT_IDX_CAP0 + c);
                p = v;
                i_src.pulse(!s, c);
                rd(`WCT_IDX_CAP0 + c);
                chk(v, p);
                rd(`WCT_IDX_CNT0);
                a = v;
                i_src.pulse(s, c);
                rd(`WCT_IDX_CNT0);
                b = v;
                rd(`WCT_IDX_CAP0 + c);
                chk(v >= a && v <= b, 1);
                rd(`WCT_IDX_STAT);
                chk(v, 32'h1 << c);
                wr(`WCT_IDX_ICLR, 32'hF);
            end
        // Block one captures from its own counter, no interrupt
        wr(`WCT_IDX_CTRL0, 32'h0);
        wr(`WCT_IDX_IEN, 32'hF);
        wr(`WCT_IDX_CTRL1, 32'h80);
        rd(`WCT_IDX_CNT1);
        a = v;
        i_src.pulse(1'b1, 0);
        rd(`WCT_IDX_CNT1);
        b = v;
        rd(`WCT_IDX_CAP0 + 4);
        chk(v >= a && v <= b, 1);
        rd(`WCT_IDX_CTRL1);
        chk(v, 32'h80);
        rd(`WCT_IDX_IEN);
        chk(v, 32'hF);
        rd(`WCT_IDX_STAT);
        chk(v, 32'h0);
        chk(irq, 1'b0);
        // Interrupt raised, masked, cleared
        wr(`WCT_IDX_IEN, 32'h1);
        i_src.pulse(1'b0, 0);
        @(posedge mclk);
        chk(irq, 1'b1);
        wr(`WCT_IDX_IEN, 32'h0);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        wr(`WCT_IDX_ICLR, 32'h1);
        wr(`WCT_IDX_IEN, 32'hF);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        // Wrap with no flag; written while half clock selected
        wr(`WCT_IDX_CNT0, 32'hFFFFFFF0);
        repeat (40) @(posedge mclk);
        rd(`WCT_IDX_CNT0);
        chk(v < 32'h40, 1);
        rd(`WCT_IDX_STAT);
        chk(v, 32'h0);
        chk(irq, 1'b0);
        // Clock bus line 1 as count clock
        wr(`WCT_IDX_CTRL0, 32'h1);
        rd(`WCT_IDX_CNT0);
        a = v;
        repeat (20) @(posedge mclk);
        rd(`WCT_IDX_CNT0);
        chk(v, a);
        i_src.clk_pulses(5);
        rd(`WCT_IDX_CNT0);
        chk(v, a + 5);
        wr(`WCT_IDX_CTRL0, 32'h0);
        // Unmapped place and read-only capture
        wr(32'h0, 32'h1);
        chk(r, `WCT_RESP_SLVERR);
        rd(32'h0);
        chk(r, `WCT_RESP_SLVERR);
        chk(v, 32'h0);
        rd(`WCT_IDX_CAP0);
        p = v;
        wr(`WCT_IDX_CAP0, 32'h5A5A5A5A);
        chk(r, `WCT_RESP_OKAY);
        rd(`WCT_IDX_CAP0);
        chk(v, p);
        finish_test;
    end
endmodule
